// *** verilog/mep_pkg.sv ***
// Shared constants, register map and helper functions of the edge pwm block
package mep_pkg;
    localparam int NUM_MATCH = 7;
    localparam int NUM_OUT = 6;
    localparam int NUM_CAP = 2;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int IDX_W = 3;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PRESCALE = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PRECOUNT = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_MATCH_CTRL = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_OUT_CTRL = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_RELEASE = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_CAP_CTRL = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_CAP0 = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_CAP1 = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h2C;
    localparam logic [ADDR_W-1:0] OFF_MATCH_BASE = 8'h40;

    // Control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_RST_BIT = 1;
    localparam int CTRL_PWM_BIT = 2;
    localparam int CTRL_CNTR_BIT = 3;
    localparam int CTRL_SRC_BIT = 4;
    localparam int CTRL_RISE_BIT = 5;
    localparam int CTRL_FALL_BIT = 6;

    // Match control: three bits per match register
    localparam int MCR_INT = 0;
    localparam int MCR_RST = 1;
    localparam int MCR_STOP = 2;
    localparam int MCR_STRIDE = 3;

    // Output control: double-edge selects low, enables from bit 8
    localparam int OCR_DBL_LO = 0;
    localparam int OCR_EN_LO = 8;

    // Capture control: three bits per capture channel
    localparam int CCR_RISE = 0;
    localparam int CCR_FALL = 1;
    localparam int CCR_INT = 2;
    localparam int CCR_STRIDE = 3;

    // Interrupt status: match events low, capture events from bit 8
    localparam int IRQ_CAP_LO = 8;

    localparam logic [DATA_W-1:0] RST_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {BUS_IDLE, BUS_RD1, BUS_RD2} mep_bus_st_t;

    // Strobe qualified by an exact register offset
    function automatic logic mep_hit(input logic stb, input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] off);
        return stb && (a == off);
    endfunction : mep_hit

    // Address falls on one of the match register words
    function automatic logic mep_is_match(input logic [ADDR_W-1:0] a);
        return (a[7:5] == OFF_MATCH_BASE[7:5]) && (a[4:2] < IDX_W'(NUM_MATCH)) && (a[1:0] == 2'h0);
    endfunction : mep_is_match

    // Match register index of a word address
    function automatic logic [IDX_W-1:0] mep_match_idx(input logic [ADDR_W-1:0] a);
        return a[4:2];
    endfunction : mep_match_idx
endpackage : mep_pkg

// *** verilog/mep_reg_if.sv ***
// Internal register access carrier between bus slave and register logic
interface mep_reg_if;
    logic wr_stb;
    logic rd_stb;
    logic [mep_pkg::ADDR_W-1:0] addr;
    logic [mep_pkg::DATA_W-1:0] wdata;
    logic [mep_pkg::DATA_W-1:0] rdata;
    modport bus (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
    modport regs (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface : mep_reg_if

// *** verilog/mep_ahb_slave.sv ***
// AHB-Lite slave turning bus transfers into register strobes
module mep_ahb_slave (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    mep_reg_if.bus rif
);
    import mep_pkg::*;

    mep_bus_st_t st_r;
    logic [ADDR_W-1:0] addr_r;
    logic wpend_r;
    logic accept;

    assign accept = hsel && htrans[1] && hready;
    assign rif.addr = addr_r;
    assign rif.wdata = hwdata;
    assign rif.wr_stb = wpend_r;
    // Read data of the bank is registered, so reads take two wait states
    assign rif.rd_stb = (st_r == BUS_RD2);

    // Transfer sequencing; writes complete with no wait state
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_r <= BUS_IDLE;
            addr_r <= '0;
            wpend_r <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= RST_ZERO;
            hresp <= 1'b0;
        end
        else
        begin
            hresp <= 1'b0; // Always OKAY
            unique case (st_r)
                BUS_IDLE:
                begin
                    wpend_r <= accept && hwrite;
                    if (accept)
                        addr_r <= haddr[ADDR_W-1:0];
                    if (accept && !hwrite)
                    begin
                        st_r <= BUS_RD1;
                        hreadyout <= 1'b0;
                    end
                end
                BUS_RD1:
                    st_r <= BUS_RD2;
                BUS_RD2:
                begin
                    st_r <= BUS_IDLE;
                    hrdata <= rif.rdata;
                    hreadyout <= 1'b1;
                end
                // The fourth code is illegal; recover to a ready bus
                default:
                begin
                    st_r <= BUS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end
endmodule : mep_ahb_slave

// *** verilog/mep_match_bank.sv ***
// Match register bank: software shadow copies and active compare values
module mep_match_bank #(
    parameter int N = 7,
    parameter int W = 32,
    parameter int IW = 3
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [IW-1:0] wr_idx,
    input wire logic [W-1:0] wr_data,
    input wire logic direct,
    input wire logic rel_en,
    input wire logic [N-1:0] rel_mask,
    input wire logic [IW-1:0] rd_idx,
    output logic [W-1:0] rd_data,
    output logic [N*W-1:0] active_flat
);
    logic [W-1:0] shadow_r [N];
    logic [W-1:0] active_r [N];

    // Shadow takes every software write
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            for (int i = 0; i < N; i++)
                shadow_r[i] <= '0;
        else if (wr_en && (int'(wr_idx) < N))
            shadow_r[wr_idx] <= wr_data;
    end

    // Active copy changes only directly or on a release
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            for (int i = 0; i < N; i++)
                active_r[i] <= '0;
        else
            for (int i = 0; i < N; i++)
                if (wr_en && direct && (int'(wr_idx) == i))
                    active_r[i] <= wr_data;
                else if (rel_en && rel_mask[i])
                    active_r[i] <= shadow_r[i];
    end

    // Registered read port shows the shadow, i.e. what software wrote
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rd_data <= '0;
        else
            rd_data <= (int'(rd_idx) < N) ? shadow_r[rd_idx] : '0;
    end

    for (genvar g = 0; g < N; g++)
    begin : g_flat
        assign active_flat[g*W +: W] = active_r[g];
    end
endmodule : mep_match_bank

// *** verilog/mep_pwm_top.sv ***
// Multi-output edge pwm timer with match, capture, prescaler and AHB-Lite registers
//
// Local design decisions: the address map and register access over AHB-Lite.
module mep_pwm_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [mep_pkg::NUM_CAP-1:0] cap_in,
    output logic [mep_pkg::NUM_OUT-1:0] pwm_out,
    output logic irq
);
    import mep_pkg::*;

    mep_reg_if rif ();

    logic [DATA_W-1:0] ctrl_r;
    logic [DATA_W-1:0] prescale_r;
    logic [DATA_W-1:0] mcr_r;
    logic [DATA_W-1:0] ocr_r;
    logic [DATA_W-1:0] ccr_r;
    logic [DATA_W-1:0] mask_r;
    logic [DATA_W-1:0] stat_r;
    logic [DATA_W-1:0] stat_nxt;
    logic [DATA_W-1:0] tc_r;
    logic [DATA_W-1:0] pc_r;
    logic [DATA_W-1:0] cap_r [NUM_CAP];
    logic [NUM_MATCH-1:0] rel_r;
    logic [NUM_CAP-1:0] cap_d_r;
    logic [NUM_OUT-1:0] pwm_q_r;
    logic [NUM_OUT-1:0] pwm_q_nxt;
    logic [DATA_W-1:0] bank_rdata;
    logic [NUM_MATCH*DATA_W-1:0] active_flat;
    logic [DATA_W-1:0] mr [NUM_MATCH];
    logic [DATA_W-1:0] tc_inc;
    logic [DATA_W-1:0] rd_mux;
    logic [NUM_MATCH-1:0] match;
    logic [NUM_MATCH-1:0] m_int;
    logic [NUM_MATCH-1:0] m_rst;
    logic [NUM_MATCH-1:0] m_stop;
    logic [NUM_CAP-1:0] cap_rise;
    logic [NUM_CAP-1:0] cap_fall;
    logic [NUM_CAP-1:0] cap_ev;
    logic [NUM_CAP-1:0] cap_int;
    logic pwm_mode;
    logic running;
    logic cnt_edge;
    logic step;
    logic tick;
    logic rst_act;
    logic stop_act;
    logic rel_en;
    logic wr_ctrl;
    logic wr_match;

    mep_ahb_slave u_slave (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .rif(rif.bus)
    );

    // Shadow writes go live at once in timer mode, else wait for a release
    mep_match_bank #(.N(NUM_MATCH), .W(DATA_W), .IW(IDX_W)) u_bank (
        .clk(hclk),
        .rstn(hresetn),
        .wr_en(wr_match),
        .wr_idx(mep_match_idx(rif.addr)),
        .wr_data(rif.wdata),
        .direct(!pwm_mode),
        .rel_en(rel_en),
        .rel_mask(rel_r),
        .rd_idx(mep_match_idx(rif.addr)),
        .rd_data(bank_rdata),
        .active_flat(active_flat)
    );

    // Mode decode; hsize is always a word here and needs no check
    assign pwm_mode = ctrl_r[CTRL_PWM_BIT];
    assign running = ctrl_r[CTRL_EN_BIT] && !ctrl_r[CTRL_RST_BIT];
    assign wr_ctrl = mep_hit(rif.wr_stb, rif.addr, OFF_CTRL);
    assign wr_match = rif.wr_stb && mep_is_match(rif.addr);
    assign cap_rise = cap_in & ~cap_d_r;
    assign cap_fall = ~cap_in & cap_d_r;

    // Count source: every clock, or selected capture input edges
    assign cnt_edge = (ctrl_r[CTRL_RISE_BIT] && cap_rise[ctrl_r[CTRL_SRC_BIT]])
                   || (ctrl_r[CTRL_FALL_BIT] && cap_fall[ctrl_r[CTRL_SRC_BIT]]);
    assign step = running && (ctrl_r[CTRL_CNTR_BIT] ? cnt_edge : 1'b1);
    assign tick = step && (pc_r == prescale_r);
    assign tc_inc = tc_r + 32'h0000_0001;

    // Match detection against the incremented count, so an action lands on that increment
    always_comb
    begin
        for (int i = 0; i < NUM_MATCH; i++)
        begin
            mr[i] = active_flat[i*DATA_W +: DATA_W];
            match[i] = tick && (tc_inc == mr[i]);
            m_int[i] = mcr_r[i*MCR_STRIDE + MCR_INT];
            m_rst[i] = mcr_r[i*MCR_STRIDE + MCR_RST];
            m_stop[i] = mcr_r[i*MCR_STRIDE + MCR_STOP];
        end
    end

    // Cycle length register always wraps the count in pwm mode
    assign rst_act = |(match & m_rst) || (pwm_mode && match[0]);
    assign stop_act = |(match & m_stop);
    // A stopped counter never reaches cycle start, so releases then apply at once
    assign rel_en = pwm_mode && (match[0] || !running);

    // Prescale counter
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pc_r <= RST_ZERO;
        else if (ctrl_r[CTRL_RST_BIT])
            pc_r <= RST_ZERO;
        else if (step)
            pc_r <= tick ? RST_ZERO : pc_r + 32'h0000_0001;
    end

    // Main counter: any period in whole counts, one period for all outputs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tc_r <= RST_ZERO;
        else if (ctrl_r[CTRL_RST_BIT])
            tc_r <= RST_ZERO;
        else if (tick)
            tc_r <= rst_act ? RST_ZERO : tc_inc;
    end

    // Control register; a stop match clears the enable unless software writes it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl_r <= RST_ZERO;
        else if (wr_ctrl)
            ctrl_r <= rif.wdata;
        else if (stop_act)
            ctrl_r[CTRL_EN_BIT] <= 1'b0;
    end

    // Plain configuration registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            prescale_r <= RST_ZERO;
            mcr_r <= RST_ZERO;
            ocr_r <= RST_ZERO;
            ccr_r <= RST_ZERO;
            mask_r <= RST_ZERO;
        end
        else
        begin
            if (mep_hit(rif.wr_stb, rif.addr, OFF_PRESCALE))
                prescale_r <= rif.wdata;
            if (mep_hit(rif.wr_stb, rif.addr, OFF_MATCH_CTRL))
                mcr_r <= rif.wdata;
            if (mep_hit(rif.wr_stb, rif.addr, OFF_OUT_CTRL))
                ocr_r <= rif.wdata;
            if (mep_hit(rif.wr_stb, rif.addr, OFF_CAP_CTRL))
                ccr_r <= rif.wdata;
            if (mep_hit(rif.wr_stb, rif.addr, OFF_IRQ_MASK))
                mask_r <= rif.wdata;
        end
    end

    // Release flags: software sets, cycle start consumes; a set in that cycle survives
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rel_r <= '0;
        else
            rel_r <= (rel_r & ~(rel_en ? rel_r : '0))
                   | (mep_hit(rif.wr_stb, rif.addr, OFF_RELEASE) ? rif.wdata[NUM_MATCH-1:0] : '0);
    end

    // Capture inputs: edge detect and snapshot of the counter
    always_comb
    begin
        for (int c = 0; c < NUM_CAP; c++)
        begin
            cap_ev[c] = (ccr_r[c*CCR_STRIDE + CCR_RISE] && cap_rise[c])
                     || (ccr_r[c*CCR_STRIDE + CCR_FALL] && cap_fall[c]);
            cap_int[c] = cap_ev[c] && ccr_r[c*CCR_STRIDE + CCR_INT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cap_d_r <= '0;
            for (int c = 0; c < NUM_CAP; c++)
                cap_r[c] <= RST_ZERO;
        end
        else
        begin
            cap_d_r <= cap_in;
            for (int c = 0; c < NUM_CAP; c++)
                if (cap_ev[c])
                    cap_r[c] <= tc_r;
        end
    end

    // Output edges; a clear wins over a set in the same count
    always_comb
    begin
        for (int k = 0; k < NUM_OUT; k++)
        begin
            logic dbl;
            logic set_e;
            dbl = (k > 0) && ocr_r[OCR_DBL_LO + k];
            set_e = dbl ? match[k] : match[0];
            if (!pwm_mode)
                pwm_q_nxt[k] = 1'b0;
            else if (match[k+1])
                pwm_q_nxt[k] = 1'b0;
            else if (set_e)
                pwm_q_nxt[k] = 1'b1;
            else
                pwm_q_nxt[k] = pwm_q_r[k];
        end
    end

    // Pin drive held low while an output is not enabled
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pwm_q_r <= '0;
            pwm_out <= '0;
        end
        else
        begin
            pwm_q_r <= pwm_q_nxt;
            pwm_out <= pwm_q_nxt & ocr_r[OCR_EN_LO +: NUM_OUT];
        end
    end

    // Sticky status, cleared by reading it; new events win over the clear
    always_comb
    begin
        stat_nxt = mep_hit(rif.rd_stb, rif.addr, OFF_IRQ_STAT) ? RST_ZERO : stat_r;
        stat_nxt[NUM_MATCH-1:0] = stat_nxt[NUM_MATCH-1:0] | (match & m_int);
        stat_nxt[IRQ_CAP_LO +: NUM_CAP] = stat_nxt[IRQ_CAP_LO +: NUM_CAP] | cap_int;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            stat_r <= RST_ZERO;
            irq <= 1'b0;
        end
        else
        begin
            stat_r <= stat_nxt;
            irq <= |(stat_nxt & mask_r);
        end
    end

    // Read data; unmapped words read as zero
    always_comb
    begin
        rd_mux = RST_ZERO;
        if (mep_is_match(rif.addr))
            rd_mux = bank_rdata;
        else
            unique case (rif.addr)
                OFF_CTRL: rd_mux = ctrl_r;
                OFF_PRESCALE: rd_mux = prescale_r;
                OFF_COUNT: rd_mux = tc_r;
                OFF_PRECOUNT: rd_mux = pc_r;
                OFF_MATCH_CTRL: rd_mux = mcr_r;
                OFF_OUT_CTRL: rd_mux = ocr_r;
                OFF_RELEASE: rd_mux = {25'h0, rel_r};
                OFF_CAP_CTRL: rd_mux = ccr_r;
                OFF_CAP0: rd_mux = cap_r[0];
                OFF_CAP1: rd_mux = cap_r[1];
                OFF_IRQ_STAT: rd_mux = stat_r;
                OFF_IRQ_MASK: rd_mux = mask_r;
                default: rd_mux = RST_ZERO;
            endcase
    end
    assign rif.rdata = rd_mux;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_start;
        pwm_mode && match[0];
    endsequence

    sequence s_idle_step;
        step && (pc_r != prescale_r);
    endsequence

    cyc_restart_a: assert property (s_start ##0 !ctrl_r[CTRL_RST_BIT] |=> tc_r == RST_ZERO)
        else $error("counter did not restart at cycle length");
    single_rise_a: assert property (s_start ##0 !match[1] |=> pwm_q_r[0])
        else $error("single-edge output did not rise at cycle start");
    const_low_a: assert property (s_start ##0 match[2] && !ocr_r[OCR_DBL_LO+1]
        |=> !pwm_q_r[1] ##1 (!pwm_q_r[1] || $past(match[0])))
        else $error("constant-low output rose");
    edge_fall_a: assert property (pwm_mode && match[1] |=> !pwm_q_r[0])
        else $error("single-edge output missed its falling edge");
    dbl_rise_a: assert property (pwm_mode && ocr_r[OCR_DBL_LO+3] && match[3] && !match[4] |=> pwm_q_r[3])
        else $error("double-edge output missed its rising edge");
    dbl_fall_a: assert property (pwm_mode && ocr_r[OCR_DBL_LO+3] && match[4] |=> !pwm_q_r[3])
        else $error("double-edge output missed its falling edge");
    rel_hold_a: assert property (pwm_mode && running && !match[0] |=> $stable(active_flat))
        else $error("match value changed outside cycle start");
    stop_clr_a: assert property (stop_act && !wr_ctrl |=> !ctrl_r[CTRL_EN_BIT] ##1 $stable(tc_r))
        else $error("stop match did not halt the counter");
    pre_hold_a: assert property (s_idle_step ##0 !ctrl_r[CTRL_RST_BIT] |=> $stable(tc_r) && pc_r == $past(pc_r) + 32'h0000_0001)
        else $error("prescaler did not hold the counter");
    timer_inc_a: assert property (!pwm_mode && tick && !rst_act && !ctrl_r[CTRL_RST_BIT] |=> tc_r == $past(tc_inc))
        else $error("timer did not advance by one");
    cnt_mode_a: assert property (running && ctrl_r[CTRL_CNTR_BIT] && !cnt_edge |=> $stable(pc_r) && $stable(tc_r))
        else $error("counter mode advanced without an input edge");
    cap_copy_a: assert property (cap_ev[0] |=> cap_r[0] == $past(tc_r))
        else $error("capture did not copy the counter");
endmodule : mep_pwm_top

// *** sim/mep_load_model.sv ***
// Load model that measures pulse timing on every pwm output
module mep_load_model (
    input wire logic clk,
    input wire logic [5:0] pwm,
    output int per_len [6],
    output int hi_len [6],
    output int rises [6]
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] prev_r = 6'h00;
    int run [6];
    int hcur [6];
    // Period between rising edges and width of the last high pulse
    always @(posedge clk)
    begin
        prev_r <= pwm;
        for (int k = 0; k < 6; k++)
        begin
            if (pwm[k] === 1'b1 && prev_r[k] !== 1'b1)
            begin
                per_len[k] <= run[k];
                run[k] <= 1;
                hcur[k] <= 1;
                rises[k] <= rises[k] + 1;
            end
            else
            begin
                run[k] <= run[k] + 1;
                hcur[k] <= hcur[k] + (pwm[k] === 1'b1 ? 1 : 0);
            end
            // A fall closes the pulse; the load sees only the level
            if (pwm[k] !== 1'b1 && prev_r[k] === 1'b1)
                hi_len[k] <= hcur[k];
        end
    end
endmodule : mep_load_model

// *** sim/tb.sv ***
// Self-checking bench of the edge pwm block with bus tasks and scenarios
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import mep_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0] cap_in = 2'h0;
    logic hreadyout, hresp, irq;
    logic [31:0] hrdata, rv;
    logic [5:0] pwm_out;
    int per_len [6];
    int hi_len [6];
    int rises [6];
    int fails = 0;
    int tests_run = 0;

    mep_pwm_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .cap_in(cap_in), .pwm_out(pwm_out), .irq(irq));
    mep_load_model load (.clk(hclk), .pwm(pwm_out), .per_len(per_len), .hi_len(hi_len), .rises(rises));

    // Clock of 100 ns period
    initial
    begin
        forever #50 hclk = ~hclk;
    end

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask : tick

    // One AHB single transfer; waits for hready in both phases
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
        chk("hresp", {31'h0, hresp}, RST_ZERO);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk(what, rv, exp);
    endtask : rd

    // Reset values and an unmapped word
    task automatic t_reset;
        chk("pwm_out", {26'h0, pwm_out}, 32'h0000_0000);
        chk("irq", {31'h0, irq}, 32'h0000_0000);
        rd("ctrl", OFF_CTRL, RST_ZERO);
        rd("out_ctrl", OFF_OUT_CTRL, RST_ZERO);
        rd("unmapped", 8'h30, RST_ZERO);
    endtask : t_reset

    // Single edge, constant low and double edge outputs sharing one period
    task automatic t_pwm;
        wr(OFF_MATCH_BASE, 32'h0000_0004);
        wr(OFF_MATCH_BASE + 8'h04, 32'h0000_0002);
        wr(OFF_MATCH_BASE + 8'h08, 32'h0000_0004);
        wr(OFF_MATCH_BASE + 8'h0C, 32'h0000_0001);
        wr(OFF_MATCH_BASE + 8'h10, 32'h0000_0002);
        wr(OFF_OUT_CTRL, 32'h0000_0B08);
        wr(OFF_RELEASE, 32'h0000_007F);
        wr(OFF_CTRL, 32'h0000_0005);
        tick(20);
        chk("period out1", per_len[0], 4);
        chk("width out1", hi_len[0], 2);
        chk("rises out2", rises[1], 0);
        chk("period out4", per_len[3], 4);
        chk("width out4", hi_len[3], 1);
        // Unreleased values must not change the pulses
        wr(OFF_MATCH_BASE + 8'h04, 32'h0000_0003);
        wr(OFF_MATCH_BASE + 8'h0C, 32'h0000_0002);
        wr(OFF_MATCH_BASE + 8'h10, 32'h0000_0001);
        tick(12);
        chk("held width out1", hi_len[0], 2);
        wr(OFF_RELEASE, 32'h0000_001A);
        tick(12);
        chk("new width out1", hi_len[0], 3);
        chk("negative out4", hi_len[3], 3);
        chk("period after", per_len[0], 4);
    endtask : t_pwm

    // Timer mode: prescaled count, stop match, masked interrupt, capture
    task automatic t_timer;
        wr(OFF_CTRL, 32'h0000_0002);
        wr(OFF_PRESCALE, 32'h0000_0002);
        wr(OFF_MATCH_BASE + 8'h0C, 32'h0000_0005);
        wr(OFF_MATCH_CTRL, 32'h0000_0A00);
        wr(OFF_IRQ_MASK, 32'h0000_0100);
        wr(OFF_CAP_CTRL, 32'h0000_0005);
        wr(OFF_CTRL, 32'h0000_0001);
        tick(30);
        rd("count stop", OFF_COUNT, 32'h0000_0005);
        rd("ctrl stop", OFF_CTRL, RST_ZERO);
        chk("irq masked", {31'h0, irq}, 32'h0000_0000);
        wr(OFF_IRQ_MASK, 32'h0000_0108);
        tick(2);
        chk("irq raised", {31'h0, irq}, 32'h0000_0001);
        rd("status", OFF_IRQ_STAT, 32'h0000_0008);
        tick(2);
        chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
        cap_in <= 2'h1;
        tick(4);
        rd("capture", OFF_CAP0, 32'h0000_0005);
        chk("irq capture", {31'h0, irq}, 32'h0000_0001);
        rd("cap status", OFF_IRQ_STAT, 32'h0000_0100);
        rd("prescale", OFF_PRESCALE, 32'h0000_0002);
    endtask : t_timer

    // Counter mode: only rising edges of capture input 0 advance the count
    task automatic t_count;
        wr(OFF_CTRL, 32'h0000_0002);
        wr(OFF_PRESCALE, RST_ZERO);
        wr(OFF_CTRL, 32'h0000_0029);
        repeat (3)
        begin
            cap_in <= 2'h0;
            tick(3);
            cap_in <= 2'h1;
            tick(3);
        end
        rd("edge count", OFF_COUNT, 32'h0000_0003);
    endtask : t_count

    task automatic print_verdict;
        if (fails == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    // Main sequence
    initial
    begin
        tick(8);
        hresetn <= 1'b1;
        tick(2);
        t_reset();
        t_pwm();
        t_timer();
        t_count();
        print_verdict();
    end

    // Watchdog well beyond the expected run
    initial
    begin
        #2000000;
        fails++;
        print_verdict();
    end
endmodule : tb
